// File: shared/ddr_gear_pkg.sv
// package: constants and types for the ddr gearbox block
package ddr_gear_pkg;
  // ----------------------------------------
  // bus map
  // ----------------------------------------
  localparam int         ADDR_W      = 4;
  localparam logic [3:0] OFS_CTRL    = 4'h0;
  localparam logic [3:0] OFS_STATUS  = 4'h4;
  localparam logic [3:0] OFS_RX_WORD = 4'h8;
  localparam logic [3:0] OFS_TX_WORD = 4'hc;
  // ----------------------------------------
  // control fields
  // ----------------------------------------
  localparam int         CTL_TX_GEAR   = 0;
  localparam int         CTL_RX_SEVEN  = 2;
  localparam int         CTL_LOOP_RST  = 3;
  localparam int         CTL_FREEZE    = 4;
  localparam int         CTL_UPDATE_N  = 5;
  localparam int         CTL_SENS_HIGH = 6;
  localparam int         CTRL_W        = 7;
  localparam logic [6:0] CTRL_RESET    = 7'h20;
  // ----------------------------------------
  // status fields
  // ----------------------------------------
  localparam int ST_LOCK     = 0;
  localparam int ST_RX_NEW   = 1;
  localparam int ST_TX_FRESH = 2;
  localparam int ST_CODE     = 8;
  localparam int ST_APPLIED  = 16;
  // ----------------------------------------
  // delay loop and gearing
  // ----------------------------------------
  localparam int         CODE_W       = 8;
  localparam int         PERIOD_W     = 10;
  localparam logic [2:0] LOCK_PERIODS = 3'd4;
  localparam logic [7:0] LOCK_TOL_LOW = 8'h01;
  localparam logic [2:0] LEN_FULL     = 3'd4;
  localparam logic [2:0] LEN_SHORT    = 3'd3;
  typedef enum logic [1:0] {gear_x1, gear_x2, gear_x4, gear_x7} tx_gear_t;
endpackage

// File: design/master_delay_loop.sv
// master delay loop: quarter period code from the sampled reference clock
`timescale 1ns/1ps
module master_delay_loop (
  // clock and reset
  input  wire logic                      i_sys_clk,
  input  wire logic                      i_sys_rst,
  // reference edge and controls
  input  wire logic                      i_ref_rise,
  input  wire logic                      i_loop_reset,
  input  wire logic                      i_freeze,
  input  wire logic                      i_code_update_n,
  input  wire logic                      i_sens_high,
  // code and lock
  output logic [ddr_gear_pkg::CODE_W-1:0] o_code,
  output logic [ddr_gear_pkg::CODE_W-1:0] o_delay_control_code,
  output logic                           o_lock
);
  import ddr_gear_pkg::*;

  typedef struct packed {
    logic [PERIOD_W-1:0] period;
    logic                primed;
    logic [CODE_W-1:0]   code;
    logic [CODE_W-1:0]   applied;
    logic [2:0]          match;
    logic                lock;
  } loop_t;

  loop_t             s;
  loop_t             next_s;
  logic [PERIOD_W-1:0] pinc;
  logic [CODE_W-1:0] quarter;
  logic [CODE_W-1:0] diff;
  logic [CODE_W-1:0] tol;

  // --------------------------------------------------------------
  // measurement and code tracking
  // --------------------------------------------------------------
  always_comb
  begin
    next_s  = s;
    pinc    = s.period + 10'h001;
    quarter = pinc[PERIOD_W-1:2];
    diff    = (quarter >= s.code) ? quarter - s.code : s.code - quarter;
    tol     = i_sens_high ? 8'h00 : LOCK_TOL_LOW;
    if (i_sys_rst)
      next_s = '0;
    else
    begin
      if (i_loop_reset)
      begin
        next_s.period = '0;
        next_s.primed = 1'b0;
        next_s.code   = '0;
        next_s.match  = '0;
        next_s.lock   = 1'b0;
      end
      else if (i_freeze)
        next_s.primed = 1'b0;
      else if (i_ref_rise)
      begin
        next_s.period = '0;
        next_s.primed = 1'b1;
        if (s.primed)
        begin
          next_s.code = quarter;
          if (diff <= tol)
          begin
            if (s.match != LOCK_PERIODS)
              next_s.match = s.match + 3'd1;
            if (s.match >= LOCK_PERIODS - 3'd1)
              next_s.lock = 1'b1;
          end
          else
          begin
            next_s.match = '0;
            next_s.lock  = 1'b0;
          end
        end
      end
      else if (s.period != '1)
        next_s.period = pinc;
      // code reaches the slave delays only while update is low
      if (!i_code_update_n)
        next_s.applied = s.code;
    end
  end

  // state register
  always_ff @(posedge i_sys_clk)
  begin
    s <= next_s;
  end

  // outputs straight from flops
  assign o_code               = s.code;
  assign o_delay_control_code = s.applied;
  assign o_lock               = s.lock;

  // --------------------------------------------------------------
  // checks
  // --------------------------------------------------------------
  default clocking dcb @(posedge i_sys_clk); endclocking
  default disable iff (i_sys_rst);

  chk_code_held: assert property (i_code_update_n |=> $stable(o_delay_control_code))
    else $error("applied code moved while update high");
  chk_code_passed: assert property (!i_code_update_n |=> o_delay_control_code == $past(o_code))
    else $error("applied code not taken while update low");
  chk_freeze_keep: assert property (i_freeze && !i_loop_reset |=> $stable(o_code) && $stable(o_lock))
    else $error("code or lock moved while frozen");
  chk_reset_unlock: assert property (i_loop_reset |=> !o_lock ##1 !o_lock || i_loop_reset == 1'b0)
    else $error("lock high during loop reset");
  chk_lock_cause: assert property ($rose(o_lock) |-> $past(i_ref_rise) && $past(s.primed))
    else $error("lock rose without a measured period");
  cov_lock: cover property ($rose(o_lock));
endmodule // master_delay_loop

// File: design/ddr_io_gearbox_with_dll.sv
// ddr gearbox top: rx 1:8/1:7, tx x1/x2/x4/7:1, delay loop, avalon slave
`timescale 1ns/1ps
module ddr_io_gearbox_with_dll (
  // clock and reset
  input  wire logic                           i_sys_clk,
  input  wire logic                           i_sys_rst,
  // avalon-mm slave
  input  wire logic [ddr_gear_pkg::ADDR_W-1:0] i_avs_address,
  input  wire logic                           i_avs_read,
  input  wire logic                           i_avs_write,
  input  wire logic [31:0]                    i_avs_writedata,
  output logic      [31:0]                    o_avs_readdata,
  output logic                                o_avs_waitrequest,
  // link pins
  input  wire logic                           i_fast_edge_clock,
  input  wire logic                           i_rx_pin,
  output logic                                o_tx_pin,
  output logic                                o_delayed_clock,
  // fabric side
  output logic      [7:0]                     o_rx_word,
  output logic                                o_rx_word_valid,
  output logic                                o_lock
);
  import ddr_gear_pkg::*;

  typedef struct packed {
    logic [1:0]        clk_sync;
    logic              clk_prev;
    logic [1:0]        pin_sync;
    logic [CTRL_W-1:0] ctrl;
    logic              waitreq;
    logic [31:0]       rdata;
    logic [7:0]        dly_cnt;
    logic              dly_busy;
    logic              dly_target;
    logic              dly_level;
    logic [3:0]        rx_nib;
    logic [1:0]        rx_cnt;
    logic              rx_upper;
    logic [3:0]        rx_hold;
    logic [7:0]        rx_word;
    logic              rx_valid;
    logic              rx_new;
    logic              rx_first;
    logic [7:0]        tx_stage1;
    logic              tx_fresh;
    logic [7:0]        tx_hold;
    logic [3:0]        tx_nib;
    logic [1:0]        tx_cnt;
    logic [2:0]        tx_len;
    logic              tx_upper;
    logic              tx_phase;
    logic              tx_pin;
  } state_t;

  state_t            s;
  state_t            next_s;
  logic [CODE_W-1:0] code;
  logic [CODE_W-1:0] applied;
  logic              lock;
  logic              clk_edge;
  logic              clk_rise;
  logic              dly_fire;
  logic              tx_load;
  logic              req;
  logic              act;
  logic              seven;
  logic [2:0]        rx_len;
  logic [3:0]        nib;
  logic [31:0]       rd;
  logic              x1_bit;
  tx_gear_t          gear;

  // --------------------------------------------------------------
  // edge detection on the synchronised edge clock
  // --------------------------------------------------------------
  assign clk_edge = s.clk_sync[1] ^ s.clk_prev;
  assign clk_rise = s.clk_sync[1] & ~s.clk_prev;
  assign seven    = s.ctrl[CTL_RX_SEVEN];
  assign gear     = tx_gear_t'(s.ctrl[CTL_TX_GEAR +: 2]);
  assign x1_bit   = s.tx_stage1[s.tx_phase];

  // one loop instance feeds every slave delay in this block
  master_delay_loop u_loop (
    .i_sys_clk            (i_sys_clk),
    .i_sys_rst            (i_sys_rst),
    .i_ref_rise           (clk_rise),
    .i_loop_reset         (s.ctrl[CTL_LOOP_RST]),
    .i_freeze             (s.ctrl[CTL_FREEZE]),
    .i_code_update_n      (s.ctrl[CTL_UPDATE_N]),
    .i_sens_high          (s.ctrl[CTL_SENS_HIGH]),
    .o_code               (code),
    .o_delay_control_code (applied),
    .o_lock               (lock)
  );

  // --------------------------------------------------------------
  // next state
  // --------------------------------------------------------------
  always_comb
  begin
    next_s   = s;
    dly_fire = 1'b0;
    tx_load  = 1'b0;
    nib      = s.rx_nib;
    rx_len   = LEN_FULL;
    rd       = '0;
    req      = i_avs_read | i_avs_write;
    act      = req & ~s.waitreq;
    // pin inputs through two flops
    next_s.clk_sync = {s.clk_sync[0], i_fast_edge_clock};
    next_s.pin_sync = {s.pin_sync[0], i_rx_pin};
    next_s.clk_prev = s.clk_sync[1];
    next_s.rx_valid = 1'b0;

    // bus: one wait cycle, then the access is taken
    next_s.waitreq = ~(req & s.waitreq);
    rd[ST_LOCK]                = lock;
    rd[ST_RX_NEW]              = s.rx_new;
    rd[ST_TX_FRESH]            = s.tx_fresh;
    rd[ST_CODE +: CODE_W]      = code;
    rd[ST_APPLIED +: CODE_W]   = applied;
    if (req && s.waitreq)
    begin
      unique case (i_avs_address)
        OFS_CTRL:    next_s.rdata = {25'h0000000, s.ctrl};
        OFS_STATUS:  next_s.rdata = rd;
        OFS_RX_WORD: next_s.rdata = {24'h000000, s.rx_word};
        OFS_TX_WORD: next_s.rdata = {24'h000000, s.tx_stage1};
        default:     next_s.rdata = 32'h00000000;
      endcase
    end
    if (act && i_avs_read && i_avs_address == OFS_RX_WORD)
      next_s.rx_new = 1'b0;

    // slave clock delay: replay each edge after code cycles
    if (s.dly_busy)
    begin
      if (s.dly_cnt == 8'h00)
      begin
        next_s.dly_level = s.dly_target;
        next_s.dly_busy  = 1'b0;
        dly_fire         = 1'b1;
      end
      else
        next_s.dly_cnt = s.dly_cnt - 8'h01;
    end
    else if (clk_edge)
    begin
      if (applied == 8'h00)
      begin
        next_s.dly_level = s.clk_sync[1];
        dly_fire         = 1'b1;
      end
      else
      begin
        next_s.dly_cnt    = applied - 8'h01;
        next_s.dly_busy   = 1'b1;
        next_s.dly_target = s.clk_sync[1];
      end
    end

    // rx: capture on both delayed edges, two halves per word
    if (seven && s.rx_upper)
      rx_len = LEN_SHORT;
    if (dly_fire)
    begin
      nib[s.rx_cnt] = s.pin_sync[1];
      next_s.rx_nib = nib;
      if (s.rx_cnt == 2'd0 && !s.rx_upper)
        next_s.rx_first = s.pin_sync[1];
      if ({1'b0, s.rx_cnt} == rx_len - 3'd1)
      begin
        next_s.rx_cnt = 2'd0;
        if (!s.rx_upper)
        begin
          next_s.rx_hold  = nib;
          next_s.rx_upper = 1'b1;
        end
        else
        begin
          next_s.rx_word  = {nib[3] & ~seven, nib[2:0], s.rx_hold};
          next_s.rx_valid = 1'b1;
          next_s.rx_new   = 1'b1;
          next_s.rx_upper = 1'b0;
        end
      end
      else
        next_s.rx_cnt = s.rx_cnt + 2'd1;
    end

    // tx x1: system clock only, bit 0 then bit 1
    if (gear == gear_x1)
    begin
      next_s.tx_phase = ~s.tx_phase;
      next_s.tx_pin   = x1_bit;
      if (s.tx_phase)
        next_s.tx_fresh = 1'b0;
    end
    // tx geared: one bit per edge clock edge, edge rate set by partner
    else if (clk_edge)
    begin
      next_s.tx_pin = s.tx_nib[s.tx_cnt];
      if ({1'b0, s.tx_cnt} != s.tx_len - 3'd1)
        next_s.tx_cnt = s.tx_cnt + 2'd1;
      else
      begin
        next_s.tx_cnt = 2'd0;
        tx_load       = 1'b1;
        if (gear == gear_x2 || !s.tx_upper)
        begin
          next_s.tx_nib   = s.tx_hold[3:0];
          next_s.tx_len   = LEN_FULL;
          next_s.tx_upper = (gear != gear_x2);
          if (gear == gear_x2)
          begin
            next_s.tx_hold  = s.tx_stage1;
            next_s.tx_fresh = 1'b0;
          end
        end
        else
        begin
          if (gear == gear_x7)
          begin
            next_s.tx_nib = {1'b0, s.tx_hold[6:4]};
            next_s.tx_len = LEN_SHORT;
          end
          else
          begin
            next_s.tx_nib = s.tx_hold[7:4];
            next_s.tx_len = LEN_FULL;
          end
          next_s.tx_upper = 1'b0;
          next_s.tx_hold  = s.tx_stage1;
          next_s.tx_fresh = 1'b0;
        end
      end
    end

    // bus writes last, so a fresh word wins over the update clear
    if (act && i_avs_write)
    begin
      if (i_avs_address == OFS_CTRL)
        next_s.ctrl = i_avs_writedata[CTRL_W-1:0];
      if (i_avs_address == OFS_TX_WORD)
      begin
        next_s.tx_stage1 = i_avs_writedata[7:0];
        next_s.tx_fresh  = 1'b1;
      end
    end

    // synchronous reset to constants
    if (i_sys_rst)
    begin
      next_s         = '0;
      next_s.ctrl    = CTRL_RESET;
      next_s.waitreq = 1'b1;
      next_s.tx_len  = LEN_FULL;
    end
  end

  // state register
  always_ff @(posedge i_sys_clk)
  begin
    s <= next_s;
  end

  // --------------------------------------------------------------
  // outputs
  // --------------------------------------------------------------
  assign o_avs_readdata    = s.rdata;
  assign o_avs_waitrequest = s.waitreq;
  assign o_tx_pin          = s.tx_pin;
  assign o_delayed_clock   = s.dly_level;
  assign o_rx_word         = s.rx_word;
  assign o_rx_word_valid   = s.rx_valid;
  assign o_lock            = lock;

  // --------------------------------------------------------------
  // checks
  // --------------------------------------------------------------
  default clocking dcb @(posedge i_sys_clk); endclocking
  default disable iff (i_sys_rst);

  chk_rx_word_pulse: assert property (o_rx_word_valid |=> !o_rx_word_valid)
    else $error("rx word strobe longer than one cycle");
  chk_rx_seven_top: assert property (o_rx_word_valid && seven |-> o_rx_word[7] == 1'b0)
    else $error("seven-bit word carries an eighth bit");
  chk_rx_first_bit: assert property (o_rx_word_valid |-> o_rx_word[0] == s.rx_first)
    else $error("word bit 0 is not the earliest bit");
  chk_rx_half_order: assert property (dly_fire && s.rx_upper && seven |-> s.rx_cnt != 2'd3)
    else $error("rx half counter out of range");
  chk_tx_x1_bit: assert property (gear == gear_x1 |=> o_tx_pin == $past(x1_bit))
    else $error("x1 pin does not follow the phase bit");
  chk_tx_edge_only: assert property (gear != gear_x1 && !clk_edge |=> $stable(o_tx_pin))
    else $error("tx pin moved without an edge clock edge");
  chk_tx_seven_len: assert property (tx_load && gear == gear_x7 && s.tx_upper |=> s.tx_len == 3'd3)
    else $error("seven-bit second transfer not three bits");
  chk_delay_wait: assert property (s.dly_busy && s.dly_cnt != 8'h00 |=> $stable(o_delayed_clock))
    else $error("delayed clock moved before its count ran out");
  chk_bus_answer: assert property (req && s.waitreq |=> !o_avs_waitrequest)
    else $error("bus access not answered after one wait cycle");

  cov_rx_eight: cover property (o_rx_word_valid && !seven);
  cov_rx_seven: cover property (o_rx_word_valid && seven);
  cov_tx_seven: cover property (tx_load && gear == gear_x7);
  cov_tx_eight: cover property (tx_load && gear == gear_x4);
endmodule // ddr_io_gearbox_with_dll

// File: verification/link_partner_model.sv
// link partner model: edge clock source, receive data source, transmit sampler
`timescale 1ns/1ps
module link_partner_model (
  // transmit pin from the block
  input  wire logic i_tx_pin,
  // edge clock and receive data to the block
  output logic      o_fast_edge_clock,
  output logic      o_rx_pin
);
  // ----------------------------------------
  // queues shared with the bench
  // ----------------------------------------
  logic tx_seen[$];
  logic rx_bits[$];

  // clock stands low and data idle outside frames
  initial
  begin
    o_fast_edge_clock = 1'b0;
    o_rx_pin          = 1'b0;
  end

  // one frame of n edges; data changes with each edge, clock then stops low
  task automatic run_edges(input int n, input realtime half);
    #3;
    for (int k = 0; k < n; k++)
    begin
      tx_seen.push_back(i_tx_pin);  // mid-bit sample of the transmit stream
      if (rx_bits.size() > 0)
        o_rx_pin = rx_bits.pop_front();  // data aligned with the clock edge
      else
        o_rx_pin = ~o_rx_pin;
      o_fast_edge_clock = ~o_fast_edge_clock;  // edge rate set by the caller
      #(half);
    end
    o_rx_pin = ~o_rx_pin;  // hold over: last bit no longer shown
  endtask
endmodule // link_partner_model

// File: verification/ddr_io_gearbox_with_dll_test.sv
// self-checking bench for the ddr gearbox: bus, transmit, receive, delay loop
`timescale 1ns/1ps
module ddr_io_gearbox_with_dll_test;
  import ddr_gear_pkg::*;
  // ----------------------------------------
  // signals and bench state
  // ----------------------------------------
  localparam int         TIMEOUT  = 20000;
  localparam logic [7:0] EXP_FAST = 8'((125 / 10) / 4);
  localparam logic [7:0] EXP_SLOW = 8'((200 / 10) / 4);
  localparam int         EDGE_LAG = 3;  // two sync flops plus edge detect
  logic                  sys_clk;
  logic                  sys_rst;
  logic [ADDR_W-1:0]     avs_address;
  logic                  avs_read;
  logic                  avs_write;
  logic [31:0]           avs_writedata;
  logic [31:0]           avs_readdata;
  logic                  avs_waitrequest;
  logic                  edge_clk;
  logic                  rx_pin;
  logic                  tx_pin;
  logic [7:0]            rx_word;
  logic                  rx_word_valid;
  logic                  lock;
  logic [7:0]            tw;
  logic [7:0]            s;
  logic [7:0]            rx_seen[$];
  logic [7:0]            rx_exp[$];
  int                    n_errors;
  int                    tests_run;
  int                    cycles;
  int                    seed;
  int                    n;
  int                    ph;
  logic                  dly_clk;
  logic                  edge_q;
  logic                  dly_q;
  int                    edge_at;
  int                    dly_lag;

  ddr_io_gearbox_with_dll ddr_io_gearbox_with_dll_i (
    .i_sys_clk(sys_clk), .i_sys_rst(sys_rst), .i_avs_address(avs_address),
    .i_avs_read(avs_read), .i_avs_write(avs_write), .i_avs_writedata(avs_writedata),
    .o_avs_readdata(avs_readdata), .o_avs_waitrequest(avs_waitrequest),
    .i_fast_edge_clock(edge_clk), .i_rx_pin(rx_pin), .o_tx_pin(tx_pin),
    .o_delayed_clock(dly_clk), .o_rx_word(rx_word), .o_rx_word_valid(rx_word_valid),
    .o_lock(lock));

  link_partner_model link_partner_model_i (
    .i_tx_pin(tx_pin), .o_fast_edge_clock(edge_clk), .o_rx_pin(rx_pin));

  // system clock, 10 ns period
  initial
  begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  // collect every received word and cut a hang short
  always @(posedge sys_clk)
  begin
    if (rx_word_valid === 1'b1) rx_seen.push_back(rx_word);
    // cycles from a seen edge clock change to the delayed clock change
    if (dly_clk !== dly_q) dly_lag = cycles - edge_at;
    if (edge_clk !== edge_q) edge_at = cycles;
    dly_q  = dly_clk;
    edge_q = edge_clk;
    cycles++;
    if (cycles == TIMEOUT)
    begin
      n_errors++;
      summarize();
    end
  end

  // ----------------------------------------
  // compare, bus and check tasks
  // ----------------------------------------
  task automatic check_val(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      n_errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic check_bit(input logic got, input logic exp);
    tests_run++;
    if (got !== exp)
    begin
      n_errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // one avalon access: hold until waitrequest is sampled low
  task automatic bus(input logic we, input logic [3:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    int k;
    k = 0;
    @(posedge sys_clk);
    avs_address   <= a;
    avs_write     <= we;
    avs_read      <= ~we;
    avs_writedata <= d;
    do
    begin
      @(posedge sys_clk);
      k++;
    end while (avs_waitrequest !== 1'b0 && k < 100);
    q = avs_readdata;
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
    if (k >= 100) n_errors++;
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask

  task automatic rd_chk(input logic [3:0] a, input logic [31:0] exp);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    check_val(q, exp);
  endtask

  // lock bit, loop code and applied code from the status register
  task automatic stat_chk(input logic lk, input logic [7:0] code, input logic [7:0] appl);
    logic [31:0] q;
    bus(1'b0, OFS_STATUS, 32'h0, q);
    check_bit(q[ST_LOCK], lk);
    check_val({24'h0, q[ST_CODE +: 8]}, {24'h0, code});
    check_val({24'h0, q[ST_APPLIED +: 8]}, {24'h0, appl});
  endtask

  // transmit samples match some rotation of the word, bit0 first
  function automatic logic rot_ok(input logic [7:0] w, input int nb);
    logic ok;
    for (int r = 0; r < nb; r++)
    begin
      ok = 1'b1;
      for (int i = 0; i < 56; i++)
        if (link_partner_model_i.tx_seen[i] !== w[(i + r) % nb]) ok = 1'b0;
      if (ok) return 1'b1;
    end
    return 1'b0;
  endfunction

  // four words of nb bits through the receive gearbox
  task automatic rx_test(input int nb);
    logic [7:0] b;
    rx_seen.delete();
    rx_exp.delete();
    for (int w = 0; w < 4; w++)
    begin
      b = 8'($random(seed));
      if (w == 0) b = 8'h40;
      if (nb == 7) b[7] = 1'b0;
      rx_exp.push_back(b);
      for (int i = 0; i < nb; i++) link_partner_model_i.rx_bits.push_back(b[i]);
    end
    link_partner_model_i.run_edges(4 * nb, 62.5);
    repeat (20) @(posedge sys_clk);
    check_val(32'(rx_seen.size()), 32'd4);
    for (int w = 0; w < 4 && w < rx_seen.size(); w++)
      check_val({24'h0, rx_seen[w]}, {24'h0, rx_exp[w]});
  endtask

  task automatic summarize();
    $display("counts: tests_run=%0d n_errors=%0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial
  begin
    sys_rst       = 1'b1;
    avs_address   = '0;
    avs_read      = 1'b0;
    avs_write     = 1'b0;
    avs_writedata = 32'h0;
    seed          = 51126;
    n_errors      = 0;
    tests_run     = 0;
    cycles        = 0;
    repeat (10) @(posedge sys_clk);
    check_bit(lock, 1'b0);
    sys_rst <= 1'b0;
    rd_chk(OFS_CTRL, {25'h0, CTRL_RESET});
    stat_chk(1'b0, 8'h00, 8'h00);
    wr(4'h2, 32'hffff_ffff);
    rd_chk(4'h2, 32'h0);
    rd_chk(OFS_CTRL, {25'h0, CTRL_RESET});
    $display("test registers done");
    // x1 transmit: pin alternates the two low bits every cycle
    for (int j = 0; j < 4; j++)
    begin
      tw = 8'($random(seed));
      tw[1:0] = j[1:0];
      wr(OFS_TX_WORD, {24'h0, tw});
      repeat (3) @(posedge sys_clk);
      for (int i = 0; i < 8; i++)
      begin
        @(posedge sys_clk);
        s[i] = tx_pin;
      end
      ph = (s[0] === tw[0]) ? 0 : 1;
      for (int i = 0; i < 8; i++) check_bit(s[i], tw[(i + ph) % 2]);
    end
    $display("test tx x1 done");
    // x2, x4 and seven-bit transmit: drain, then capture a steady stream
    for (int g = 1; g < 4; g++)
    begin
      n = (g == 1) ? 4 : ((g == 2) ? 8 : 7);
      tw = (g == 2) ? 8'h17 : 8'($random(seed));
      wr(OFS_CTRL, 32'h20 | 32'(g));
      wr(OFS_TX_WORD, {24'h0, tw});
      link_partner_model_i.run_edges(56, 62.5);
      @(posedge sys_clk);
      link_partner_model_i.tx_seen.delete();
      link_partner_model_i.run_edges(56, 62.5);
      @(posedge sys_clk);
      check_bit(rot_ok(tw, n), 1'b1);
    end
    $display("test tx gears done");
    // lock, then pass the code on while update is low
    link_partner_model_i.run_edges(64, 62.5);
    repeat (10) @(posedge sys_clk);
    check_bit(lock, 1'b1);
    stat_chk(1'b1, EXP_FAST, 8'h00);
    wr(OFS_CTRL, 32'h03);  // update between frames only
    repeat (4) @(posedge sys_clk);
    wr(OFS_CTRL, 32'h23);
    stat_chk(1'b1, EXP_FAST, EXP_FAST);
    $display("test delay loop done");
    rx_test(8);
    rd_chk(OFS_RX_WORD, {24'h0, rx_exp[3]});
    wr(OFS_CTRL, 32'h27);
    rx_test(7);
    $display("test rx done");
    // freeze keeps the code while the rate changes, release tracks it
    wr(OFS_CTRL, 32'h37);  // freeze raised before the slower clock starts
    link_partner_model_i.run_edges(32, 100.0);
    repeat (10) @(posedge sys_clk);
    stat_chk(1'b1, EXP_FAST, EXP_FAST);
    check_val(32'(dly_lag), 32'(EDGE_LAG) + {24'h0, EXP_FAST});
    wr(OFS_CTRL, 32'h27);
    link_partner_model_i.run_edges(64, 100.0);
    repeat (10) @(posedge sys_clk);
    stat_chk(1'b1, EXP_SLOW, EXP_FAST);
    $display("test freeze done");
    // loop reset clears lock and code, applied code held
    wr(OFS_CTRL, 32'h2f);
    repeat (3) @(posedge sys_clk);
    check_bit(lock, 1'b0);
    stat_chk(1'b0, 8'h00, EXP_FAST);
    wr(OFS_CTRL, 32'h67);  // high jitter sensitivity
    // 15.75-cycle period: quarters of 3 and 4 mix, never four equal in a row
    link_partner_model_i.run_edges(64, 78.75);
    repeat (10) @(posedge sys_clk);
    check_bit(lock, 1'b0);
    link_partner_model_i.run_edges(64, 62.5);
    repeat (10) @(posedge sys_clk);
    stat_chk(1'b1, EXP_FAST, EXP_FAST);
    $display("test loop reset done");
    summarize();
  end
endmodule // ddr_io_gearbox_with_dll_test
